// File: src/spi_boost_pkg.sv
/*
 * shared constants for the four-wire register link and the boost control block.
 * assumes a single 100 MHz clock on both ends.
 */
package spi_boost_pkg;
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS  = 7;
  localparam int DATA_BITS  = 8;
  // register addresses
  localparam logic [6:0] ADDR_VOLTAGE_CODE = 7'h05;
  localparam logic [6:0] ADDR_POWER_CTRL   = 7'h06;
  localparam logic [6:0] ADDR_RESULT_HI    = 7'h07;
  localparam logic [6:0] ADDR_RESULT_LO    = 7'h08;
  // general control fields
  localparam int BIT_CHIP_ACTIVE   = 0;
  localparam int BIT_BOOST_RUN     = 1;
  localparam int BIT_ADAPTIVE      = 2;
  localparam int BIT_ACTIVE_LOAD   = 3;
  localparam int BIT_COMP_SELECT   = 4;
  localparam int BIT_READOUT_SEL   = 5;
  // reset values
  localparam logic [7:0] RESET_POWER_CTRL   = 8'h04;
  localparam logic [7:0] RESET_VOLTAGE_CODE = 8'h05;
  // voltage code limits
  localparam logic [7:0] VCODE_MIN = 8'h05;
  localparam logic [7:0] VCODE_MAX = 8'h14;
  // timing
  localparam int  CLK_HZ         = 100_000_000;
  localparam int  SOFT_START_MS  = 50;
  localparam int  SOFT_START_CYC = CLK_HZ / 1000 * SOFT_START_MS;
  localparam int  SCK_HALF_CYC   = 4;
  // host command register map (apb)
  localparam logic [11:0] HOST_CMD    = 12'h000;
  localparam logic [11:0] HOST_STATUS = 12'h004;
  localparam logic [11:0] HOST_RDATA  = 12'h008;
endpackage : spi_boost_pkg

// File: src/spi_link_if.sv
/*
 * four-wire serial link between host and device.
 * assumes both ends on pclk; the device samples the pins through synchronisers.
 */
interface spi_link_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  // device end
  modport device (input sck, input ss_n, input mosi, output miso, output miso_oe);
  // host end
  modport host (output sck, output ss_n, output mosi, input miso, input miso_oe);
endinterface : spi_link_if

// File: src/spi_boost_device.sv
/*
 * device end: serial slave, control registers and boost control logic.
 * assumes host keeps slave select low over a whole frame and high between frames.
 */
module spi_boost_device import spi_boost_pkg::*; #(
  parameter int SOFT_START = SOFT_START_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link pins
  spi_link_if.device       link,
  input  wire logic        if_select,
  // sensor results and driver feedback
  input  wire logic [11:0] first_sensor_input,
  input  wire logic [11:0] second_sensor_input,
  input  wire logic [2:0]  driver_low,
  input  wire logic [2:0]  driver_high,
  input  wire logic        high_current,
  input  wire logic        stand_alone,
  // converter controls
  output logic             chip_active,
  output logic             boost_run,
  output logic             boost_soft,
  output logic             active_load,
  output logic             comp_second,
  output logic [4:0]       boost_target,
  output logic             headroom_high
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] sck_s, ss_s, mosi_s, if_s;
  logic       sck_d;
  // interface select is a pin too; link ignored until it is seen high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s  <= 2'b00;
      ss_s   <= 2'b11;
      mosi_s <= 2'b00;
      if_s   <= 2'b00;
      sck_d  <= 1'b0;
    end else begin
      sck_s  <= {sck_s[0], link.sck};
      ss_s   <= {ss_s[0], link.ss_n};
      mosi_s <= {mosi_s[0], link.mosi};
      if_s   <= {if_s[0], if_select};
      sck_d  <= sck_s[1];
    end
  end

  logic spi_mode;
  logic sck_rise, sck_fall, ss_high;
  assign spi_mode = if_s[1];
  assign ss_high  = ss_s[1] | ~spi_mode;
  assign sck_rise = sck_s[1] & ~sck_d;
  assign sck_fall = ~sck_s[1] & sck_d;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] power_ctrl, voltage_code;
  logic [15:0] shift_in;
  logic [4:0]  bit_count;
  logic        commit;
  assign commit = sck_rise & ~ss_high & (bit_count == 5'd15) & shift_in[7];

  function automatic logic [7:0] read_mux(input logic [6:0] a);
    logic [11:0] res;
    res = power_ctrl[BIT_READOUT_SEL] ? second_sensor_input : first_sensor_input;
    case (a)
      ADDR_VOLTAGE_CODE: read_mux = voltage_code;
      ADDR_POWER_CTRL:   read_mux = power_ctrl;
      ADDR_RESULT_HI:    read_mux = res[11:4];
      ADDR_RESULT_LO:    read_mux = {res[3:0], 4'h0};
      default:           read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // register writes, only on a complete frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ctrl   <= RESET_POWER_CTRL;
      voltage_code <= RESET_VOLTAGE_CODE;
    end else if (commit) begin
      case (shift_in[14:8])
        ADDR_POWER_CTRL:   power_ctrl <= {shift_in[6:0], mosi_s[1]};
        ADDR_VOLTAGE_CODE: voltage_code <= {shift_in[6:0], mosi_s[1]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial receive and transmit
  logic [7:0] tx_byte;
  logic       tx_active;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_in  <= 16'h0000;
      bit_count <= 5'd0;
    end else if (ss_high) begin
      shift_in  <= 16'h0000;
      bit_count <= 5'd0;
    end else if (sck_rise && bit_count != 5'd16) begin
      shift_in  <= {shift_in[14:0], mosi_s[1]};
      bit_count <= bit_count + 5'd1;
    end
  end

  // read data out on falling edges after the direction bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte   <= 8'h00;
      tx_active <= 1'b0;
    end else if (ss_high) begin
      tx_byte   <= 8'h00;
      tx_active <= 1'b0;
    end else if (sck_fall) begin
      if (bit_count == 5'd8 && !shift_in[0]) begin
        tx_byte   <= read_mux(shift_in[7:1]);
        tx_active <= 1'b1;
      end else if (tx_active && bit_count > 5'd8 && bit_count < 5'd16) begin
        tx_byte <= {tx_byte[6:0], 1'b0};
      end else if (bit_count == 5'd16) begin
        tx_active <= 1'b0;
      end
    end
  end
  assign link.miso    = tx_byte[7];
  assign link.miso_oe = tx_active;

  ////////////////////////////////////////////////////////////////////////////
  // boost control
  logic [$clog2(SOFT_START+1)-1:0] soft_count;
  logic [7:0] clamped;
  logic [4:0] adapt_code;
  logic       adaptive;

  assign chip_active = power_ctrl[BIT_CHIP_ACTIVE];
  assign boost_run   = power_ctrl[BIT_BOOST_RUN] & chip_active;
  assign active_load = power_ctrl[BIT_ACTIVE_LOAD];
  assign comp_second = power_ctrl[BIT_COMP_SELECT];
  assign adaptive    = power_ctrl[BIT_ADAPTIVE] | stand_alone;
  assign headroom_high = high_current;
  assign clamped = (voltage_code < VCODE_MIN) ? VCODE_MIN :
                   (voltage_code > VCODE_MAX) ? VCODE_MAX : voltage_code;

  // soft-start timer after boost_run (run bit and chip active both set) goes high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_count <= '0;
      boost_soft <= 1'b0;
    end else if (!boost_run) begin
      soft_count <= '0;
      boost_soft <= 1'b0;
    end else if (soft_count != SOFT_START[$bits(soft_count)-1:0]) begin
      soft_count <= soft_count + 1'b1;
      boost_soft <= 1'b1;
    end else begin
      boost_soft <= 1'b0;
    end
  end

  // adaptive target tracks lowest driver headroom
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adapt_code <= VCODE_MIN[4:0];
    end else if (!adaptive) begin
      adapt_code <= clamped[4:0];
    end else if (|driver_low && adapt_code != VCODE_MAX[4:0]) begin
      adapt_code <= adapt_code + 5'd1;
    end else if (&driver_high && adapt_code != VCODE_MIN[4:0]) begin
      adapt_code <= adapt_code - 5'd1;
    end
  end

  // target register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_target <= VCODE_MIN[4:0];
    end else begin
      boost_target <= adaptive ? adapt_code : clamped[4:0];
    end
  end

endmodule : spi_boost_device

// File: src/spi_boost_host.sv
/*
 * host end: apb slave command registers driving the serial master.
 * assumes the device samples pins on pclk through synchronisers.
 */
module spi_boost_host import spi_boost_pkg::*; #(
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link pins
  spi_link_if.host         link
);

  typedef enum logic [1:0] {IDLE = 2'b00, SHIFT = 2'b01, GAP = 2'b10} state_t;
  state_t     state;
  logic [15:0] frame;
  logic [4:0]  bits;
  logic [3:0]  div;
  logic [7:0]  rdata;
  logic [1:0]  miso_s;
  logic        start, tick;

  assign pready  = 1'b1;
  assign pslverr = psel & penable &
                   !(paddr == HOST_CMD || paddr == HOST_STATUS || paddr == HOST_RDATA);
  assign start   = psel & penable & pwrite & (paddr == HOST_CMD) & (state == IDLE);
  assign tick    = (div == HALF_CYC[3:0] - 4'd1);

  ////////////////////////////////////////////////////////////////////////////
  // apb read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        HOST_STATUS: prdata <= {31'h0000_0000, state != IDLE};
        HOST_RDATA:  prdata <= {24'h00_0000, rdata};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // miso synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) miso_s <= 2'b00;
    else          miso_s <= {miso_s[0], link.miso};
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial master: ss low over frame, mosi changes while sck low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= IDLE;
      frame     <= 16'h0000;
      bits      <= 5'd0;
      div       <= 4'd0;
      rdata     <= 8'h00;
      link.sck  <= 1'b0;
      link.ss_n <= 1'b1;
      link.mosi <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          div <= 4'd0;
          if (start) begin
            frame     <= pwdata[15:0];
            link.ss_n <= 1'b0;
            link.mosi <= pwdata[15];
            bits      <= 5'd0;
            state     <= SHIFT;
          end
        end
        SHIFT: begin
          div <= tick ? 4'd0 : div + 4'd1;
          // take miso two cycles after the rise: the pin value at the rise, past its synchroniser
          if (link.sck && div == 4'd1 && bits >= 5'd8) begin
            rdata <= {rdata[6:0], miso_s[1]};
          end
          if (tick) begin
            if (!link.sck) begin
              link.sck <= 1'b1;
            end else begin
              link.sck <= 1'b0;
              bits     <= bits + 5'd1;
              frame    <= {frame[14:0], 1'b0};
              link.mosi <= frame[14];
              if (bits == 5'd15) state <= GAP;
            end
          end
        end
        GAP: begin
          div <= tick ? 4'd0 : div + 4'd1;
          if (tick) begin
            link.ss_n <= 1'b1;
            state     <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

endmodule : spi_boost_host

// File: test/spi_link_properties.sv
/* link checker: frame, clock and output-enable relations.
   assumes host and device on one pclk, HALF_CYC of 4. */
module spi_link_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link pins
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       sck_q;
  logic [4:0] rises;
  logic [4:0] falls;
  ////////////////////////////////////////
  // count clock edges inside a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      rises <= 5'h00;
      falls <= 5'h00;
    end else begin
      sck_q <= sck;
      rises <= ss_n ? 5'h00 : rises + 5'(sck & !sck_q);
      falls <= ss_n ? 5'h00 : falls + 5'(!sck & sck_q);
    end
  end
  a_oe_idle_off: assert property (ss_n [*5] |-> !miso_oe) else $error("output on while deselected");
  a_sck_idle_low: assert property (ss_n |-> !sck) else $error("clock moved outside a frame");
  a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi)) else $error("mosi moved in high phase");
  a_sck_half: assert property ($rose(sck) |-> sck [*4] ##1 !sck) else $error("clock high phase wrong");
  a_frame_bits: assert property ($rose(ss_n) |-> rises == 5'd16) else $error("frame not 16 bits");
  a_oe_after_eighth: assert property ($rose(miso_oe) |-> falls == 5'd8) else $error("output on too early");
  a_oe_not_early: assert property ($fell(miso_oe) |-> falls == 5'd16 || ss_n) else $error("output off early");
  a_frame_gap: assert property ($rose(ss_n) |-> ss_n [*2]) else $error("select gap too short");
  a_miso_hold: assert property (miso_oe && sck && $past(sck) |-> $stable(miso)) else $error("miso moved in high phase");
endmodule : spi_link_properties

// File: test/spi_slave_boost_control_tb.sv
/* testbench: apb writes orders to the host end, which talks to the device end.
   assumes status bit0 shows a frame in progress. */
module spi_slave_boost_control_tb import spi_boost_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, if_select = 1'b1, high_current = 1'b0, stand_alone = 1'b0;
  logic [11:0] res_a = 12'hABC, res_b = 12'h123;
  logic [2:0]  drv_low = 3'h0, drv_high = 3'h0;
  logic        chip_active, boost_run, boost_soft, active_load, comp_second, headroom_high;
  logic [4:0]  boost_target;
  logic [7:0]  rd;
  logic        err;
  int          miscompares = 0, checked = 0;
  ////////////////////////////////////////
  // clock, link and both ends
  always #5 pclk = ~pclk;
  spi_link_if spi_link_if_i ();
  spi_boost_host #(.HALF_CYC(4)) spi_boost_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(spi_link_if_i.host));
  spi_boost_device #(.SOFT_START(60)) spi_boost_device_i (.pclk, .presetn, .link(spi_link_if_i.device),
    .if_select, .first_sensor_input(res_a), .second_sensor_input(res_b), .driver_low(drv_low),
    .driver_high(drv_high), .high_current, .stand_alone, .chip_active, .boost_run, .boost_soft,
    .active_load, .comp_second, .boost_target, .headroom_high);
  spi_link_properties spi_link_properties_i (.pclk, .presetn, .sck(spi_link_if_i.sck),
    .ss_n(spi_link_if_i.ss_n), .mosi(spi_link_if_i.mosi), .miso(spi_link_if_i.miso),
    .miso_oe(spi_link_if_i.miso_oe));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // one frame, then wait for busy to clear and fetch read data
  task automatic xfer(input logic [6:0] a, input logic wr, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, HOST_CMD, {16'h0000, a, wr, d}, r);
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) apb(1'b0, HOST_STATUS, 32'h0000_0000, r);
    repeat (4) @(posedge pclk);
    apb(1'b0, HOST_RDATA, 32'h0000_0000, r);
    rd = r[7:0];
  endtask : xfer
  task automatic t_reset;
    xfer(ADDR_POWER_CTRL, 1'b0, 8'h00);
    chk("ctrl reset", RESET_POWER_CTRL, rd);
    xfer(ADDR_VOLTAGE_CODE, 1'b0, 8'h00);
    chk("code reset", RESET_VOLTAGE_CODE, rd);
    chk("target reset", 5'd5, boost_target);
  endtask : t_reset
  task automatic t_run;
    xfer(ADDR_POWER_CTRL, 1'b1, 8'h02);
    chk("run no chip", 2'b00, {chip_active, boost_run});
    xfer(ADDR_POWER_CTRL, 1'b1, 8'h03);
    chk("run on", 3'b111, {chip_active, boost_run, boost_soft});
    repeat (60) @(posedge pclk);
    chk("soft done", 1'b0, boost_soft);
    xfer(ADDR_POWER_CTRL, 1'b0, 8'h00);
    chk("ctrl readback", 8'h03, rd);
  endtask : t_run
  task automatic t_code;
    logic [7:0] codes [7] = '{8'h00, 8'h04, 8'h05, 8'h0C, 8'h14, 8'h15, 8'hFF};
    foreach (codes[k]) begin
      xfer(ADDR_VOLTAGE_CODE, 1'b1, codes[k]);
      chk("target", codes[k] < 5 ? 5'd5 : codes[k] > 20 ? 5'd20 : codes[k][4:0], boost_target);
      xfer(ADDR_VOLTAGE_CODE, 1'b0, 8'h00);
      chk("code readback", codes[k], rd);
    end
  endtask : t_code
  task automatic t_bits;
    xfer(ADDR_POWER_CTRL, 1'b1, 8'h3B);
    chk("load comp", 2'b11, {active_load, comp_second});
    xfer(ADDR_RESULT_HI, 1'b0, 8'h00);
    chk("second hi", res_b[11:4], rd);
    xfer(ADDR_RESULT_LO, 1'b0, 8'h00);
    chk("second lo", {res_b[3:0], 4'h0}, rd);
    xfer(ADDR_POWER_CTRL, 1'b1, 8'h03);
    chk("load comp off", 2'b00, {active_load, comp_second});
    xfer(ADDR_RESULT_HI, 1'b0, 8'h00);
    chk("first hi", res_a[11:4], rd);
  endtask : t_bits
  task automatic t_adapt;
    xfer(ADDR_VOLTAGE_CODE, 1'b1, 8'h0C);
    xfer(ADDR_POWER_CTRL, 1'b1, 8'h07);
    drv_low <= 3'h1;
    high_current <= 1'b1;
    repeat (30) @(posedge pclk);
    chk("adapt up", 5'd20, boost_target);
    chk("headroom", 1'b1, headroom_high);
    drv_low <= 3'h0;
    drv_high <= 3'h7;
    repeat (30) @(posedge pclk);
    chk("adapt down", 5'd5, boost_target);
    drv_high <= 3'h0;
    high_current <= 1'b0;
    xfer(ADDR_POWER_CTRL, 1'b1, 8'h03);
    chk("manual", 5'd12, boost_target);
    stand_alone <= 1'b1;
    drv_low <= 3'h1;
    repeat (30) @(posedge pclk);
    chk("stand alone", 5'd20, boost_target);
    stand_alone <= 1'b0;
    drv_low <= 3'h0;
    repeat (3) @(posedge pclk);
    chk("back manual", 5'd12, boost_target);
  endtask : t_adapt
  task automatic t_abort;
    logic [31:0] r;
    apb(1'b1, HOST_CMD, {16'h0000, ADDR_POWER_CTRL, 1'b1, 8'hFF}, r);
    repeat (60) @(posedge pclk);
    if_select <= 1'b0;
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) apb(1'b0, HOST_STATUS, 32'h0000_0000, r);
    if_select <= 1'b1;
    repeat (4) @(posedge pclk);
    xfer(ADDR_POWER_CTRL, 1'b0, 8'h00);
    chk("cut frame", 8'h03, rd);
    if_select <= 1'b0;
    repeat (4) @(posedge pclk);
    xfer(ADDR_VOLTAGE_CODE, 1'b1, 8'h10);
    if_select <= 1'b1;
    repeat (4) @(posedge pclk);
    xfer(ADDR_VOLTAGE_CODE, 1'b0, 8'h00);
    chk("link off", 8'h0C, rd);
    apb(1'b0, 12'h0FC, 32'h0000_0000, r);
    chk("unmapped", 1'b1, err);
  endtask : t_abort
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // main sequence after a five-cycle reset
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_run();
    t_code();
    t_bits();
    t_adapt();
    t_abort();
    end_of_test();
  end
  // watchdog cuts a hang short
  initial begin
    #200_000;
    miscompares++;
    end_of_test();
  end
endmodule : spi_slave_boost_control_tb
